// >>> iwh_pkg.sv
// shared constants and carriers for the interrupt, watchdog and halt control block
package iwh_pkg;
    localparam logic [7:0] REG_WDT_PRESCALE = 8'h09;
    localparam logic [7:0] REG_IRQ_LOW      = 8'h0b;
    localparam logic [7:0] REG_IRQ_HIGH     = 8'h1e;
    localparam logic [7:0] REG_SYS_STATUS   = 8'h20;
    localparam logic [11:0] ADDR_WDT_PRESCALE = 12'h024;
    localparam logic [11:0] ADDR_IRQ_LOW      = 12'h02c;
    localparam logic [11:0] ADDR_IRQ_HIGH     = 12'h078;
    localparam logic [11:0] ADDR_SYS_STATUS   = 12'h080;
    // low register bits
    localparam int B_GIE  = 0;
    localparam int B_EEI  = 1;
    localparam int B_E0I  = 2;
    localparam int B_E1I  = 3;
    localparam int B_EPF  = 4;
    localparam int B_C0F  = 5;
    localparam int B_C1F  = 6;
    // high register bits
    localparam int B_E3I  = 1;
    localparam int B_C3F  = 5;
    localparam logic [7:0] LOW_MASK  = 8'h7f;
    localparam logic [7:0] HIGH_MASK = 8'h22;
    localparam logic [7:0] WATCHDOG_PRESCALE_REGISTER_MASK = 8'h07;
    localparam logic [7:0] WATCHDOG_PRESCALE_REGISTER_RESET = 8'h07;
    // status bits
    localparam int B_PDF = 0;
    localparam int B_WTO = 1;
    localparam int B_HALTED = 2;
    localparam logic [7:0] VEC_EXT = 8'h04;
    localparam logic [7:0] VEC_C0  = 8'h08;
    localparam logic [7:0] VEC_C1  = 8'h0c;
    localparam logic [7:0] VEC_C3  = 8'h14;
    localparam int WDT_CHAIN_BITS = 8;
    localparam int WAKE_DELAY_CLKS = 1024;
    localparam int SYS_CLK_DIV = 4;
    localparam int PHASE_TWO_SLOT = 1;
    typedef struct packed {
        logic       interrupt_exit;
        logic       subroutine_exit;
        logic       watchdog_clear;
        logic       sleep;
        logic       stack_full;
    } iwh_core_t;
    typedef struct packed {
        logic       ack;
        logic [7:0] vector;
        logic       warm_reset;
        logic       chip_reset;
        logic       resume;
    } iwh_core_out_t;
endpackage

// >>> iwh_ctrl.sv
// interrupt vectoring, watchdog and halt/wake sequencing with an apb register port
//
// Functional notes
// R1: interrupt_exit sets global enable; subroutine_exit leaves it alone.
// R2: further acknowledges wait until exit or enables set with stack room.
// R3: requests are sampled and serviced at the next phase-two pulse.
// R4: fixed priority external, counter0, counter1, counter3 with their vectors.
// R5: service needs global and individual enable; global clear masks all.
// R6: pending flags stay set until serviced or cleared by software.
// R7: unused bits of both interrupt control registers read zero.
// R8: halt stops the system oscillator; external clock ignored while halted.
// R9: rc configuration drives system clock divided by four on clock_out_pin.
// R10: watchdog source is a build-time choice: rc or instruction clock.
// R11: watchdog disabled at build time makes every watchdog operation inert.
// R12: watchdog clock first passes an eight-stage divide-by-256 chain.
// R13: prescale field bits 2..0 divides further by two to the field.
// R14: overflow in normal run gives full chip reset and sets expired flag.
// R15: overflow while halted gives warm reset of program counter and stack only.
// R16: chip clear pin, clear instruction or sleep clear counter and prescaler.
// R17: halt entry keeps state, restarts watchdog, sets powerdown, clears expired.
// R18: halt ends on reset, interrupt, enabled port falling edge or overflow; overflow wake here needs the rc source.
// R19: port wake bits chosen at build time; port wake resumes next instruction.
// R20: interrupt wake with disable or full stack resumes; else vectors.
// R21: wake waits 1024 clocks; an acknowledging wake adds one more cycle.
// R22: a flag already pending at halt entry cannot wake the device.
// R23: vectoring clears that pending flag and the global enable.
// R24: no acknowledge while the return stack is full.
module iwh_ctrl
    import iwh_pkg::*;
#(
    parameter bit         WDT_ENABLE    = 1'b1,
    parameter bit         WDT_USE_RC    = 1'b1,
    parameter bit         RC_OSC_CONFIG = 1'b1,
    parameter logic [7:0] PORT_WAKE_EN  = 8'hff,
    parameter int         WAKE_DELAY    = WAKE_DELAY_CLKS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    input  wire logic        chip_clear_pin_n,
    input  wire logic        wdt_rc_tick,
    input  wire logic        ext_irq_event,
    input  wire logic        counter0_overflow,
    input  wire logic        counter1_overflow,
    input  wire logic        counter3_overflow,
    input  wire logic [7:0]  port_a,
    input  wire iwh_core_t   core,
    output      iwh_core_out_t core_out,
    output      logic        sys_osc_enable,
    output      logic        clock_out_pin
);
    initial begin
        if (WAKE_DELAY < 1 || WAKE_DELAY > 65535)
            $error("wake delay out of range");
        // phase and divider counters are two bits wide
        if (SYS_CLK_DIV != 4 || PHASE_TWO_SLOT >= SYS_CLK_DIV)
            $error("clock divider constants do not fit the phase counter");
        if (WDT_CHAIN_BITS != 8)
            $error("watchdog chain must have eight stages");
    end

    // halt freezes the clock dividers; wake counts the restart delay
    // so the oscillator can settle before any instruction runs
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_HALT = 3'b010,
        ST_WAKE = 3'b100
    } iwh_state_t;

    // all state in one word, read data register included
    typedef struct packed {
        iwh_state_t  st;
        logic [7:0]  irq_low;
        logic [7:0]  irq_high;
        logic [7:0]  watchdog_prescale_register;
        logic        powerdown_flag;
        logic        wto;
        logic [1:0]  phase;
        logic [1:0]  inst_div;
        logic [7:0]  chain;
        logic [6:0]  presc;
        logic        chain_tick_d;
        logic [15:0] wake_cnt;
        logic        wake_ack;
        logic [3:0]  halt_masked;
        logic [7:0]  port_d;
        logic        in_isr;
        logic        ack;
        logic [7:0]  vector;
        logic        warm;
        logic        chip;
        logic        resume;
        logic        clkout;
        logic [31:0] rdata;
    } iwh_s_t;

    iwh_s_t s;
    iwh_s_t next_s;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] r);
        return a == r;
    endfunction

    // a write lands in the access cycle and only with the low byte lane on
    function automatic logic wr_hit(input logic w, input logic [3:0] b, input logic [11:0] a, input logic [11:0] r);
        return w && b[0] && is_addr(a, r);
    endfunction

    // lowest index wins: external first, counter3 last
    function automatic logic [1:0] prio_pick(input logic [3:0] r);
        logic [1:0] p;
        p = 2'd3;
        for (int i = 3; i >= 0; i--) begin
            if (r[i])
                p = 2'(i);
        end
        return p;
    endfunction

    // vector for the chosen source
    function automatic logic [7:0] vec_of(input logic [1:0] k);
        case (k)
            2'd0:    return VEC_EXT;
            2'd1:    return VEC_C0;
            2'd2:    return VEC_C1;
            default: return VEC_C3;
        endcase
    endfunction

    // status is read-only, so a write to it is refused
    function automatic logic is_mapped(input logic [11:0] a, input logic w);
        logic hit;
        hit = is_addr(a, ADDR_IRQ_LOW) || is_addr(a, ADDR_IRQ_HIGH) || is_addr(a, ADDR_WDT_PRESCALE);
        hit = hit || (is_addr(a, ADDR_SYS_STATUS) && !w);
        return hit;
    endfunction

    // unused bits are masked here so they always read as zero
    function automatic logic [7:0] rd_byte(input logic [11:0] a, input iwh_s_t v);
        logic [7:0] b;
        b = '0;
        if (is_addr(a, ADDR_IRQ_LOW))
            b = v.irq_low & LOW_MASK;
        else if (is_addr(a, ADDR_IRQ_HIGH))
            b = v.irq_high & HIGH_MASK;
        else if (is_addr(a, ADDR_WDT_PRESCALE))
            b = v.watchdog_prescale_register & WATCHDOG_PRESCALE_REGISTER_MASK;
        else if (is_addr(a, ADDR_SYS_STATUS)) begin
            b[B_PDF]    = v.powerdown_flag;
            b[B_WTO]    = v.wto;
            b[B_HALTED] = v.st == ST_HALT;
        end
        return b;
    endfunction

    // last count of the restart delay
    localparam logic [15:0] WAKE_LAST = 16'(WAKE_DELAY - 1);

    // decoded views of the state for this cycle
    logic [3:0] pend;
    logic [3:0] ena;
    logic [3:0] req;
    logic       wr;
    logic       rd;
    logic       wdt_src;
    logic       wdt_clr;
    logic       ovf;
    logic       irq_wake;
    logic       port_wake;
    logic [7:0] vec;
    logic [1:0] sel;
    logic       ack_ok;
    logic       presc_last;

    // request, watchdog and wake decoding shared by the state logic
    always_comb begin
        pend = {s.irq_high[B_C3F], s.irq_low[B_C1F], s.irq_low[B_C0F], s.irq_low[B_EPF]};
        ena  = {s.irq_high[B_E3I], s.irq_low[B_E1I], s.irq_low[B_E0I], s.irq_low[B_EEI]};
        // service enables
        // R5: both enables gate
        req  = s.irq_low[B_GIE] ? (pend & ena) : 4'h0;
        wr   = psel && penable && pwrite;
        rd   = psel && !penable && !pwrite;
        // R10: build-time source
        wdt_src = WDT_USE_RC ? wdt_rc_tick : (s.inst_div == 2'(SYS_CLK_DIV - 1));
        // the pin clear is a level and holds the count at zero
        // R16: three clear causes
        wdt_clr = !chip_clear_pin_n || core.watchdog_clear || core.sleep;
        // R13: select prescale output
        presc_last = (s.watchdog_prescale_register[2:0] == 3'd0) || (s.presc == (7'h7f >> (3'd7 - s.watchdog_prescale_register[2:0])));
        ovf        = WDT_ENABLE && s.chain_tick_d && presc_last;
        // R22: masked flags cannot wake
        irq_wake  = |(pend & ~s.halt_masked);
        // R19: per-bit wake selection
        port_wake = |(s.port_d & ~port_a & PORT_WAKE_EN);
        // R2: nested service only after software re-enables
        ack_ok = !s.in_isr || s.irq_low[B_GIE];
        // R4: fixed priority
        sel = prio_pick(req);
        vec = vec_of(sel);
    end

    // next-state logic: every register's new value is formed here
    always_comb begin
        next_s = s;
        next_s.ack    = 1'b0;
        next_s.warm   = 1'b0;
        next_s.chip   = 1'b0;
        next_s.resume = 1'b0;
        // previous port level; reset low so no false falling edge follows
        next_s.port_d = port_a;
        // phase and divider stop in halt, like the stopped oscillator
        // R9: clock divided by four
        if (s.st != ST_HALT) begin
            next_s.inst_div = s.inst_div + 2'd1;
            next_s.phase    = s.phase + 2'd1;
            if (s.inst_div == 2'(SYS_CLK_DIV / 2 - 1))
                next_s.clkout = 1'b1;
            if (s.inst_div == 2'(SYS_CLK_DIV - 1))
                next_s.clkout = 1'b0;
        end

        // R6: flags sticky, software clear
        if (wr_hit(wr, pstrb, paddr, ADDR_IRQ_LOW))
            next_s.irq_low = pwdata[7:0] & LOW_MASK;
        if (wr_hit(wr, pstrb, paddr, ADDR_IRQ_HIGH))
            next_s.irq_high = pwdata[7:0] & HIGH_MASK;
        if (wr_hit(wr, pstrb, paddr, ADDR_WDT_PRESCALE))
            next_s.watchdog_prescale_register = pwdata[7:0] & WATCHDOG_PRESCALE_REGISTER_MASK;
        // an event in the cycle of a software clear must not be lost
        // set wins over a clearing write
        if (ext_irq_event)
            next_s.irq_low[B_EPF] = 1'b1;
        if (counter0_overflow)
            next_s.irq_low[B_C0F] = 1'b1;
        if (counter1_overflow)
            next_s.irq_low[B_C1F] = 1'b1;
        if (counter3_overflow)
            next_s.irq_high[B_C3F] = 1'b1;

        // R1: exit restores global enable
        if (core.interrupt_exit) begin
            next_s.irq_low[B_GIE] = 1'b1;
            next_s.in_isr = 1'b0;
        end

        // on the instruction-clock source the chain stops with the oscillator,
        // so only the rc source can end a halt by overflow
        // R12: eight-stage chain
        next_s.chain_tick_d = 1'b0;
        if (s.st != ST_HALT || WDT_USE_RC)
            if (!WDT_ENABLE) begin
                next_s.chain = '0;
            end else if (wdt_src) begin
                next_s.chain = s.chain + 8'd1;
                next_s.chain_tick_d = (s.chain == 8'hff);
            end
        if (s.chain_tick_d)
            next_s.presc = ovf ? 7'd0 : s.presc + 7'd1;
        // R11: inert without watchdog
        if (WDT_ENABLE && wdt_clr) begin
            next_s.chain = '0;
            next_s.presc = '0;
            next_s.chain_tick_d = 1'b0;
            if (core.watchdog_clear) begin
                next_s.powerdown_flag = 1'b0;
                next_s.wto = 1'b0;
            end
        end

        case (s.st)
            ST_RUN: begin
                // R3: serviced at phase-two pulse
                // R2: held while routine runs without reenable
                // R24: full stack blocks
                if (s.phase == 2'(PHASE_TWO_SLOT) && |req && ack_ok && !core.stack_full) begin
                    next_s.ack    = 1'b1;
                    next_s.vector = vec;
                    next_s.in_isr = 1'b1;
                    // R23: clear flag and global enable
                    next_s.irq_low[B_GIE] = 1'b0;
                    case (sel)
                        2'd0:    next_s.irq_low[B_EPF] = ext_irq_event;
                        2'd1:    next_s.irq_low[B_C0F] = counter0_overflow;
                        2'd2:    next_s.irq_low[B_C1F] = counter1_overflow;
                        default: next_s.irq_high[B_C3F] = counter3_overflow;
                    endcase
                end
                if (ovf) begin
                    // R14: full reset, expired set
                    next_s.chip = 1'b1;
                    next_s.wto  = 1'b1;
                    next_s.irq_low  = '0;
                    next_s.irq_high = '0;
                    next_s.in_isr   = 1'b0;
                end else if (core.sleep) begin
                    // R17: halt entry flags
                    next_s.st  = ST_HALT;
                    next_s.powerdown_flag = 1'b1;
                    next_s.wto = 1'b0;
                    // flags pending now are recorded so they cannot wake
                    next_s.halt_masked = pend;
                end
            end
            ST_HALT: begin
                // overflow is taken first since it also resets the stack
                // R18: wake sources
                if (ovf) begin
                    // R15: warm reset only
                    next_s.warm = 1'b1;
                    next_s.wto  = 1'b1;
                    next_s.st   = ST_WAKE;
                    next_s.wake_cnt = '0;
                    next_s.wake_ack = 1'b0;
                end else if (irq_wake || port_wake) begin
                    next_s.st = ST_WAKE;
                    next_s.wake_cnt = '0;
                    // R20: vector only if enabled with room
                    next_s.wake_ack = |(req & ~s.halt_masked) && !core.stack_full;
                end
            end
            ST_WAKE: begin
                // the count starts at zero on each wake entry
                // R21: wake delay
                next_s.wake_cnt = s.wake_cnt + 16'd1;
                if (s.wake_cnt == WAKE_LAST) begin
                    next_s.st = ST_RUN;
                    next_s.resume = !s.wake_ack;
                    // an acknowledging wake re-enters a slot early, delaying the routine
                    next_s.phase = s.wake_ack ? 2'(PHASE_TWO_SLOT - 1) : s.phase;
                end
            end
            default: next_s.st = ST_RUN;
        endcase

        // R7: unused bits zero
        // read data is taken in the setup cycle and held through the access
        if (rd)
            next_s.rdata = 32'(rd_byte(paddr, s));
    end

    // one register for all state keeps reset values in one place
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.st <= ST_RUN;
            s.watchdog_prescale_register <= WATCHDOG_PRESCALE_REGISTER_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs come straight from the state register, handshake aside
    always_comb begin
        pready  = 1'b1;
        pslverr = psel && penable && !is_mapped(paddr, pwrite);
        prdata  = s.rdata;
        core_out.ack        = s.ack;
        core_out.vector     = s.vector;
        core_out.warm_reset = s.warm;
        core_out.chip_reset = s.chip;
        core_out.resume     = s.resume;
        // R8: oscillator stops in halt
        sys_osc_enable = s.st != ST_HALT;
        // the pin idles low when a crystal owns it
        clock_out_pin  = RC_OSC_CONFIG ? s.clkout : 1'b0;
    end
endmodule

// >>> iwh_sva.sv
// port-level assertions for the interrupt, watchdog and halt block
module iwh_sva
    import iwh_pkg::*;
#(
    parameter int WAKE_DELAY = 8
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic [7:0]    port_a,
    input wire iwh_core_t     core,
    input wire iwh_core_out_t core_out,
    input wire logic          sys_osc_enable,
    input wire logic          clock_out_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // slack of a few clocks for edge detection and the registered pulse
    localparam int WLO = WAKE_DELAY - 1;
    localparam int WHI = WAKE_DELAY + 4;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rise_run;
        $rose(clock_out_pin) && sys_osc_enable ##1 sys_osc_enable [*2];
    endsequence
    sequence s_port_wake;
        $fell(port_a[3]) && !sys_osc_enable;
    endsequence
    chk_ack_gap: assert property (core_out.ack |=> !core_out.ack [*3]) else $error("ack too soon");
    chk_ack_room: assert property (core_out.ack |-> !$past(core.stack_full)) else $error("ack on full");
    chk_vec_fixed: assert property (core_out.ack |-> core_out.vector inside {8'h04, 8'h08, 8'h0c, 8'h14})
        else $error("bad vector");
    chk_osc_halt: assert property (core.sleep |=> !sys_osc_enable) else $error("osc runs in halt");
    chk_warm_halt: assert property (core_out.warm_reset |-> !$past(sys_osc_enable)) else $error("warm in run");
    chk_chip_run: assert property (core_out.chip_reset |-> $past(sys_osc_enable)) else $error("chip in halt");
    chk_out_div: assert property (s_rise_run |-> !clock_out_pin && $past(clock_out_pin)) else $error("clk div");
    chk_wake_wait: assert property (s_port_wake |-> ##[WLO:WHI] core_out.resume) else $error("wake delay");
endmodule

bind iwh_ctrl iwh_sva #(.WAKE_DELAY(WAKE_DELAY)) u_sva (.pclk(pclk), .presetn(presetn), .port_a(port_a),
    .core(core), .core_out(core_out), .sys_osc_enable(sys_osc_enable), .clock_out_pin(clock_out_pin));

// >>> iwh_core_model.sv
// core stand-in: return stack depth, service time and routine exits
module iwh_core_model
    import iwh_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire iwh_core_out_t core_out,
    input  wire logic          ret_sub,
    input  wire logic          fill,
    input  wire logic          sleep_req,
    input  wire logic          wdclr_req,
    input  wire logic [7:0]    svc,
    output      iwh_core_t     core
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] depth;
    logic [7:0] cnt;
    logic       busy;
    logic [1:0] ret;
    // fill stands for calls nested by software, so a full stack is legal
    assign core = {ret, wdclr_req, sleep_req, fill || depth == 4'h8};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            depth <= 4'h0;
            cnt   <= 8'h00;
            busy  <= 1'b0;
            ret   <= 2'b00;
        end else begin
            ret <= 2'b00;
            if (core_out.chip_reset || core_out.warm_reset) begin
                depth <= 4'h0;
                busy  <= 1'b0;
            end else if (core_out.ack) begin
                depth <= depth + 4'h1;
                busy  <= 1'b1;
                cnt   <= svc;
            end else if (busy && cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else if (busy) begin
                busy  <= 1'b0;
                depth <= depth - 4'h1;
                ret   <= {!ret_sub, ret_sub};
            end
        end
    end
endmodule

// >>> iwh_ctrl_tb.sv
// self-checking bench for the interrupt, watchdog and halt block
module iwh_ctrl_tb import iwh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, tick, tick_on;
    logic          ret_sub, fill, sleep_req, wdclr_req, osc, clk_out, clr_n;
    logic [3:0]    irq_ev;
    logic [7:0]    port_a, svc;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, r;
    iwh_core_t     core;
    iwh_core_out_t co;
    int            n_mismatch, n_tests, n, n_ack;
    wire logic [4:0] ev = {core.subroutine_exit, co.chip_reset, co.warm_reset, co.resume, co.ack};
    iwh_ctrl #(.WAKE_DELAY(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chip_clear_pin_n(clr_n), .wdt_rc_tick(tick), .ext_irq_event(irq_ev[3]),
        .counter0_overflow(irq_ev[2]), .counter1_overflow(irq_ev[1]), .counter3_overflow(irq_ev[0]),
        .port_a(port_a), .core(core), .core_out(co), .sys_osc_enable(osc), .clock_out_pin(clk_out));
    iwh_core_model u_core (.pclk(pclk), .presetn(presetn), .core_out(co), .ret_sub(ret_sub), .fill(fill),
        .sleep_req(sleep_req), .wdclr_req(wdclr_req), .svc(svc), .core(core));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        tick <= tick_on && !tick;
        if (co.ack === 1'b1) n_ack <= n_ack + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic fail_wait;
        n_mismatch++;
        $display("MISMATCH t=%0t wait ran out", $time);
        print_verdict();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 9; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 9) fail_wait();
        // idle cycle so a following call does not drive psel twice in one step
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, e);
    endtask
    task automatic wait_ev(input int b, input int lim);
        for (n = 0; n < lim && ev[b] !== 1'b1; n++) @(posedge pclk);
        if (n == lim) fail_wait();
    endtask
    task automatic do_sleep;
        sleep_req <= 1'b1;
        @(posedge pclk);
        sleep_req <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_regs;
        apb(1'b1, ADDR_IRQ_LOW, 32'h0000_00fe);
        rd_chk(ADDR_IRQ_LOW, 32'h0000_007e);
        apb(1'b1, ADDR_IRQ_HIGH, 32'h0000_00ff);
        rd_chk(ADDR_IRQ_HIGH, 32'h0000_0022);
        rd_chk(ADDR_WDT_PRESCALE, 32'h0000_0007);
        apb(1'b1, ADDR_WDT_PRESCALE, 32'h0000_00fd);
        rd_chk(ADDR_WDT_PRESCALE, 32'h0000_0005);
        rd_chk(12'h100, 32'h0000_0000);
        chk(32'(serr), 32'h1);
        apb(1'b1, ADDR_IRQ_LOW, 32'h0000_0000);
        apb(1'b1, ADDR_IRQ_HIGH, 32'h0000_0002);
        $display("register test done");
    endtask
    task automatic t_prio;
        logic [7:0] vt[4] = '{VEC_EXT, VEC_C0, VEC_C1, VEC_C3};
        int m;
        apb(1'b1, ADDR_IRQ_LOW, 32'h0000_000e);
        irq_ev <= 4'hf;
        @(posedge pclk);
        irq_ev <= 4'h0;
        m = n_ack;
        repeat (12) @(posedge pclk);
        chk(32'(n_ack), 32'(m));
        rd_chk(ADDR_IRQ_LOW, 32'h0000_007e);
        apb(1'b1, ADDR_IRQ_LOW, 32'h0000_007f);
        for (int k = 0; k < 4; k++) begin
            wait_ev(0, 40);
            chk(co.vector, vt[k]);
            @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
        rd_chk(ADDR_IRQ_LOW, 32'h0000_000f);
        rd_chk(ADDR_IRQ_HIGH, 32'h0000_0002);
        $display("priority test done");
    endtask
    task automatic t_mask;
        int m;
        svc <= 8'h10;
        fill <= 1'b1;
        apb(1'b1, ADDR_IRQ_LOW, 32'h0000_0005);
        irq_ev <= 4'h4;
        @(posedge pclk);
        irq_ev <= 4'h0;
        m = n_ack;
        repeat (12) @(posedge pclk);
        chk(32'(n_ack), 32'(m));
        rd_chk(ADDR_IRQ_LOW, 32'h0000_0025);
        fill <= 1'b0;
        wait_ev(0, 40);
        chk(co.vector, VEC_C0);
        ret_sub <= 1'b1;
        wait_ev(4, 60);
        rd_chk(ADDR_IRQ_LOW, 32'h0000_0004);
        ret_sub <= 1'b0;
        $display("mask test done");
    endtask
    task automatic t_halt;
        do_sleep();
        chk(32'(osc), 32'h0);
        rd_chk(ADDR_SYS_STATUS, 32'h0000_0005);
        port_a <= 8'hf7;
        wait_ev(1, 40);
        @(posedge pclk);
        chk(32'(osc), 32'h1);
        port_a <= 8'hff;
        $display("halt test done");
    endtask
    task automatic t_wdt;
        int e;
        for (int f = 0; f < 2; f++) begin
            e = 512 << f;
            apb(1'b1, ADDR_WDT_PRESCALE, 32'(f));
            wdclr_req <= 1'b1;
            @(posedge pclk);
            wdclr_req <= 1'b0;
            tick_on <= 1'b1;
            // a mid-count clear from the pin must restart the count
            if (f == 1) begin
                repeat (200) @(posedge pclk);
                clr_n <= 1'b0;
                @(posedge pclk);
                clr_n <= 1'b1;
            end
            wait_ev(3, 1200);
            tick_on <= 1'b0;
            chk(32'(n + 9 > e && n < e + 9), 32'h1);
            rd_chk(ADDR_SYS_STATUS, 32'h0000_0002);
        end
        apb(1'b1, ADDR_WDT_PRESCALE, 32'h0000_0000);
        do_sleep();
        tick_on <= 1'b1;
        wait_ev(2, 700);
        tick_on <= 1'b0;
        chk(32'(n + 9 > 512 && n < 521), 32'h1);
        wait_ev(1, 60);
        rd_chk(ADDR_SYS_STATUS, 32'h0000_0003);
        $display("watchdog test done");
    endtask
    initial begin
        {presetn, psel, penable, pwrite, tick, tick_on, ret_sub, fill, sleep_req, wdclr_req} = '0;
        {paddr, pwdata, irq_ev, svc} = '0;
        port_a = 8'hff;
        clr_n = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_prio();
        t_mask();
        t_halt();
        t_wdt();
        print_verdict();
    end
endmodule
